// File: bus_cycle.v
// One asynchronous write or read cycle on the flash pins
`include "prot_defines.vh"
module bus_cycle #(
  parameter AW = 26,
  parameter HOLD = `BUS_CYC
) (
  input wire core_clk,
  input wire sys_rst,
  input wire start,
  input wire rd,
  input wire [AW-1:0] addr,
  input wire [15:0] wdata,
  input wire [15:0] dq_in,
  output reg [AW-1:0] fl_addr,
  output reg [15:0] dq_out,
  output reg dq_oe_n,
  output reg ce_n,
  output reg we_n,
  output reg oe_n,
  output reg [15:0] rdata,
  output wire busy,
  output reg done
);
  reg [7:0] cnt_r;
  reg act_r;
  reg rd_r;
  assign busy = act_r;
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 8'h00;
      act_r <= 1'b0;
      rd_r <= 1'b0;
      fl_addr <= {AW{1'b0}};
      dq_out <= 16'h0000;
      dq_oe_n <= 1'b1;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      rdata <= 16'h0000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!act_r && start) begin
        act_r <= 1'b1;
        rd_r <= rd;
        cnt_r <= HOLD[7:0];
        fl_addr <= addr;
        dq_out <= wdata;
        dq_oe_n <= rd;
        ce_n <= 1'b0;
        we_n <= rd;
        oe_n <= ~rd;
      end else if (act_r) begin
        if (cnt_r == 8'h00) begin
          act_r <= 1'b0;
          ce_n <= 1'b1;
          we_n <= 1'b1;
          oe_n <= 1'b1;
          dq_oe_n <= 1'b1;
          done <= 1'b1;
          if (rd_r) begin
            rdata <= dq_in;
          end
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end
endmodule

// File: flash_prot_model.sv
// Behavioural device keeping the block protection flags
module flash_prot_model (
  input wire core_clk,
  input wire sys_rst,
  input wire [25:0] fl_addr,
  input wire [15:0] dq_out,
  input wire ce_n,
  input wire we_n,
  input wire oe_n,
  output wire [15:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] vol;
  logic [15:0] nv = 16'hffff;
  logic lock, arm, ex, clr, wl, ok;
  logic [2:0] uk;
  // One-time mode select: nothing in here ever clears it
  logic pmode = 1'b0;
  logic [1:0] u;
  logic [7:0] mode;
  logic [15:0] pw [4];
  logic [15:0] rv, last;
  wire [3:0] b = fl_addr[19:16];
  // Nonvolatile flags are left out of reset on purpose
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vol <= 16'hffff;
      lock <= ~pmode;
      {u, mode, arm, ex, clr, wl, uk, ok} <= '0;
    end else begin
      wl <= !ce_n && !we_n;
      if (!ce_n && !we_n && !wl) begin
        if (u == 2'd2) begin
          mode <= dq_out[7:0];
          u <= 2'd0;
        end else if (dq_out == 16'h00aa && fl_addr == 26'h555) u <= 2'd1;
        else if (u == 2'd1) u <= 2'd2;
        else if (ex) begin
          mode <= 8'h00;
          ex <= 1'b0;
        end else if (uk != 3'd0) begin
          uk <= (uk == 3'd6) ? 3'd0 : uk + 3'd1;
          if (uk >= 3'd2 && uk <= 3'd5 && dq_out != pw[uk[1:0] - 2'd2])
            ok <= 1'b0;
          if (uk == 3'd6 && ok && pmode && dq_out[7:0] == 8'h29)
            lock <= 1'b1;
        end else if (arm) begin
          arm <= 1'b0;
          case (mode)
            8'he0: vol[b] <= dq_out[0];
            8'hc0: if (lock) nv[b] <= 1'b0;
            8'h50: lock <= 1'b0;
            8'h60: if (!pmode) pw[fl_addr[1:0]] <= dq_out;
            default: ;
          endcase
        end else if (clr) begin
          clr <= 1'b0;
          if (lock && dq_out[7:0] == 8'h30) nv <= 16'hffff;
        end else if (dq_out[7:0] == 8'ha0) arm <= 1'b1;
        else if (dq_out[7:0] == 8'h80) clr <= 1'b1;
        else if (mode == 8'h60 && dq_out[7:0] == 8'h25) begin
          uk <= 3'd1;
          ok <= 1'b1;
        end
        else if (dq_out[7:0] == 8'h90) ex <= 1'b1;
      end
    end
  end
  always @* begin
    case (mode)
      8'he0: rv = {15'd0, vol[b]};
      8'hc0: rv = {15'd0, nv[b]};
      8'h50: rv = {15'd0, lock};
      8'h60: rv = pmode ? 16'h0000 : pw[fl_addr[1:0]];
      8'h90: rv = {15'd0, ~(vol[b] & nv[b])};
      default: rv = 16'h0000;
    endcase
  end
  always @(posedge core_clk) if (oe_n) last <= ~rv;
  assign dq_in = (!ce_n && !oe_n) ? rv : last;
endmodule

// File: prot_defines.vh
// Command codes, cycle addresses and bus timing for the protection host
// Summary of operation
// [R1] Each block has its own volatile flag
// [R2] Volatile flag matters only when nonvolatile is 1
// [R3] Set writes 00, clear writes 01
// [R4] Volatile flags reset to 1 unprotected
// [R5] Nonvolatile flag set per block by command
// [R6] Lock flag 0 refuses nonvolatile changes
// [R7] Lock flag 1 allows set and clear-all
// [R8] Only reset restores lock outside password mode
// [R9] Nonvolatile flags cleared all together only
// [R10] Host locks only after configuring nonvolatile flags; prot_host issues OP_LOCK whenever requested, without checking the order
// [R11] Host sets lock early in boot; prot_host sets lock only on an OP_LOCK request
// [R12] Both flags act alike when pin high
// [R13] Password mode: 64-bit match releases lock
// [R14] Password mode forces lock 0 at reset
// [R15] Correct password unlock sets lock to 1
// [R16] Password read back before mode activation only
// [R17] Password mode select 0 is permanent
// [R18] Status 00h if both flags 1, else 01h
// [R19] Status read through identification query mode
// [R20] Program or erase on protected block ignored
// [R21] Pin low protects highest or lowest block
// [R22] Mode select flags are one-time programmable
// [R23] Volatile set: A0h then 00 to block
`ifndef PROT_DEFINES_VH
`define PROT_DEFINES_VH
`define UNLK_ADDR1 16'h0555
`define UNLK_ADDR2 16'h02aa
`define UNLK_DATA1 16'h00aa
`define UNLK_DATA2 16'h0055
`define SET_LOCKREG 16'h0040
`define SET_PWD 16'h0060
`define SET_NVPROT 16'h00c0
`define SET_LOCKBIT 16'h0050
`define SET_VPROT 16'h00e0
`define SET_AUTOSEL 16'h0090
`define CMD_PROG 16'h00a0
`define CMD_EXIT 16'h0090
`define DAT_EXIT 16'h0000
`define CMD_CLR_ALL1 16'h0080
`define CMD_CLR_ALL2 16'h0030
`define CMD_UNLOCK1 16'h0025
`define CMD_UNLOCK2 16'h0003
`define CMD_UNLOCK_END 16'h0029
`define DAT_PROT 16'h0000
`define DAT_UNPROT 16'h0001
`define ADDR_PROT_STAT 16'h0002
`define STAT_UNPROT 8'h00
`define STAT_PROT 8'h01
`define BUS_T_NS 40
`define CLK_NS 4
`define BUS_CYC ((`BUS_T_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// File: prot_host.v
// Host sequencer issuing flash block protection command cycles
`include "prot_defines.vh"
module prot_host #(
  parameter AW = 26
) (
  input wire core_clk,
  input wire sys_rst,
  input wire req,
  input wire [3:0] op,
  input wire [AW-1:0] blk_addr,
  input wire [63:0] password,
  output wire ready,
  output reg ack,
  output reg [15:0] result,
  output wire [AW-1:0] fl_addr,
  output wire [15:0] dq_out,
  output wire dq_oe_n,
  input wire [15:0] dq_in,
  output wire ce_n,
  output wire we_n,
  output wire oe_n
);
  // Operation codes on op
  localparam OP_VSET = 4'h0;
  localparam OP_VCLR = 4'h1;
  localparam OP_VRD = 4'h2;
  localparam OP_NVSET = 4'h3;
  localparam OP_NVCLR = 4'h4;
  localparam OP_NVRD = 4'h5;
  localparam OP_LOCK = 4'h6;
  localparam OP_LKRD = 4'h7;
  localparam OP_PWPROG = 4'h8;
  localparam OP_PWRD = 4'h9;
  localparam OP_UNLOCK = 4'ha;
  localparam OP_STAT = 4'hb;
  localparam S_IDLE = 2'd0;
  localparam S_RUN = 2'd1;
  localparam S_WAIT = 2'd2;
  reg [1:0] st_r;
  reg [4:0] idx_r;
  reg [3:0] op_r;
  reg [AW-1:0] ba_r;
  reg [63:0] pw_r;
  reg go_r;
  reg rd_r;
  reg [AW-1:0] a_r;
  reg [15:0] d_r;
  reg last_r;
  wire [15:0] rdata;
  wire cyc_done;
  wire cyc_busy;
  assign ready = (st_r == S_IDLE);

  // ************************************************
  // Command cycle table
  // ************************************************
  function [15:0] set_code;
    input [3:0] o;
    begin
      if (o <= OP_VRD) begin
        set_code = `SET_VPROT;
      end else if (o <= OP_NVRD) begin
        set_code = `SET_NVPROT;
      end else if (o <= OP_LKRD) begin
        set_code = `SET_LOCKBIT;
      end else if (o <= OP_UNLOCK) begin
        set_code = `SET_PWD;
      end else begin
        set_code = `SET_AUTOSEL;
      end
    end
  endfunction

  function [15:0] pw_word;
    input [63:0] p;
    input [1:0] n;
    begin
      pw_word = p[n*16 +: 16];
    end
  endfunction

  // Slots 0..2 enter the command set; body slots follow; exit closes
  reg [AW-1:0] a_c;
  reg [15:0] d_c;
  reg rd_c;
  reg last_c;
  reg exit_c;
  always @* begin
    a_c = {AW{1'b0}};
    d_c = 16'h0000;
    rd_c = 1'b0;
    last_c = 1'b0;
    exit_c = 1'b0;
    case (idx_r)
      5'd0: begin
        a_c = {{(AW-16){1'b0}}, `UNLK_ADDR1};
        d_c = `UNLK_DATA1;
      end
      5'd1: begin
        a_c = {{(AW-16){1'b0}}, `UNLK_ADDR2};
        d_c = `UNLK_DATA2;
      end
      5'd2: begin
        a_c = {{(AW-16){1'b0}}, `UNLK_ADDR1};
        d_c = set_code(op_r);
      end
      default: begin
        case (op_r)
          OP_VSET, OP_VCLR, OP_NVSET, OP_LOCK: begin
            if (idx_r == 5'd3) begin
              d_c = `CMD_PROG; // [R23]
            end else if (idx_r == 5'd4) begin
              a_c = ba_r; // [R1] [R5]
              d_c = (op_r == OP_VCLR) ? `DAT_UNPROT : `DAT_PROT; // [R3]
            end else begin
              exit_c = 1'b1; // [R10] [R11]
            end
          end
          OP_NVCLR: begin
            if (idx_r == 5'd3) begin
              d_c = `CMD_CLR_ALL1; // [R9]
            end else if (idx_r == 5'd4) begin
              d_c = `CMD_CLR_ALL2; // [R9]
            end else begin
              exit_c = 1'b1;
            end
          end
          OP_VRD, OP_NVRD, OP_LKRD: begin
            if (idx_r == 5'd3) begin
              a_c = (op_r == OP_LKRD) ? {AW{1'b0}} : ba_r;
              rd_c = 1'b1;
            end else begin
              exit_c = 1'b1;
            end
          end
          OP_STAT: begin
            if (idx_r == 5'd3) begin
              a_c = ba_r | {{(AW-16){1'b0}}, `ADDR_PROT_STAT}; // [R19]
              rd_c = 1'b1;
            end else begin
              exit_c = 1'b1;
            end
          end
          OP_PWPROG: begin
            if (idx_r < 5'd11) begin
              if (idx_r[0]) begin
                d_c = `CMD_PROG;
              end else begin
                a_c = {{(AW-2){1'b0}}, idx_r[2:1] - 2'd2};
                d_c = pw_word(pw_r, idx_r[2:1] - 2'd2); // [R16]
              end
            end else begin
              exit_c = 1'b1;
            end
          end
          OP_PWRD: begin
            if (idx_r < 5'd7) begin
              a_c = {{(AW-2){1'b0}}, idx_r[1:0] - 2'd3};
              rd_c = 1'b1; // [R16]
            end else begin
              exit_c = 1'b1;
            end
          end
          default: begin
            // Unlock: 25h, 03h at offset 0, four words at offsets 0..3, then 29h at offset 0
            if (idx_r == 5'd3) begin
              d_c = `CMD_UNLOCK1; // [R13] [R15]
            end else if (idx_r == 5'd4) begin
              d_c = `CMD_UNLOCK2;
            end else if (idx_r < 5'd9) begin
              a_c = {{(AW-2){1'b0}}, idx_r[1:0] - 2'd1};
              d_c = pw_word(pw_r, idx_r[1:0] - 2'd1); // [R13]
            end else if (idx_r == 5'd9) begin
              d_c = `CMD_UNLOCK_END;
            end else begin
              exit_c = 1'b1;
            end
          end
        endcase
      end
    endcase
    if (exit_c) begin
      if (idx_r[0] == exit_phase(op_r)) begin
        d_c = `CMD_EXIT;
      end else begin
        d_c = `DAT_EXIT;
        last_c = 1'b1;
      end
    end
  end

  function exit_phase;
    input [3:0] o;
    begin
      case (o)
        OP_VSET, OP_VCLR, OP_NVSET, OP_LOCK, OP_NVCLR, OP_PWPROG,
        OP_PWRD: begin
          exit_phase = 1'b1;
        end
        default: begin
          exit_phase = 1'b0;
        end
      endcase
    end
  endfunction

  // ************************************************
  // Sequencer
  // ************************************************
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= S_IDLE;
      idx_r <= 5'd0;
      op_r <= 4'h0;
      ba_r <= {AW{1'b0}};
      pw_r <= 64'h0;
      go_r <= 1'b0;
      rd_r <= 1'b0;
      a_r <= {AW{1'b0}};
      d_r <= 16'h0000;
      last_r <= 1'b0;
      ack <= 1'b0;
      result <= 16'h0000;
    end else begin
      ack <= 1'b0;
      go_r <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (req) begin
            op_r <= op;
            ba_r <= blk_addr;
            pw_r <= password;
            idx_r <= 5'd0;
            st_r <= S_RUN;
          end
        end
        S_RUN: begin
          if (!cyc_busy) begin
            a_r <= a_c;
            d_r <= d_c;
            rd_r <= rd_c;
            last_r <= last_c;
            go_r <= 1'b1;
            st_r <= S_WAIT;
          end
        end
        default: begin
          if (cyc_done) begin
            if (rd_r) begin
              if (op_r == OP_STAT) begin
                result <= {8'h00, rdata[7:0]}; // [R18]
              end else if (op_r == OP_PWRD) begin
                result <= rdata; // [R16]
              end else begin
                result <= {15'h0000, rdata[0]}; // [R2] [R12]
              end
            end
            if (last_r) begin
              ack <= 1'b1;
              st_r <= S_IDLE;
            end else begin
              idx_r <= idx_r + 5'd1;
              st_r <= S_RUN;
            end
          end
        end
      endcase
    end
  end

  bus_cycle #(
    .AW(AW)
  ) u_cyc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(go_r),
    .rd(rd_r),
    .addr(a_r),
    .wdata(d_r),
    .dq_in(dq_in),
    .fl_addr(fl_addr),
    .dq_out(dq_out),
    .dq_oe_n(dq_oe_n),
    .ce_n(ce_n),
    .we_n(we_n),
    .oe_n(oe_n),
    .rdata(rdata),
    .busy(cyc_busy),
    .done(cyc_done)
  );
endmodule

// File: prot_host_props.sv
// Pin protocol checker for the protection host
module prot_host_props #(
  parameter AW = 26
) (
  input wire core_clk,
  input wire sys_rst,
  input wire req,
  input wire [3:0] op,
  input wire [AW-1:0] blk_addr,
  input wire [63:0] password,
  input wire ready,
  input wire ack,
  input wire [15:0] result,
  input wire [AW-1:0] fl_addr,
  input wire [15:0] dq_out,
  input wire dq_oe_n,
  input wire [15:0] dq_in,
  input wire ce_n,
  input wire we_n,
  input wire oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_wr; !we_n |-> !dq_oe_n && !ce_n && oe_n; endproperty
  a_wr: assert property (p_wr) else $error("bad write");
  property p_rd; !oe_n |-> dq_oe_n && !ce_n && we_n; endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  property p_ack; ack |-> ready ##1 !ack; endproperty
  a_ack: assert property (p_ack) else $error("bad ack");
  property p_take; req && ready |=> !ready; endproperty
  a_take: assert property (p_take) else $error("not taken");
  property p_go; req && ready |-> ##[1:8] !ce_n; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_hold;
    !we_n && $past(!we_n) |-> $stable(fl_addr) && $stable(dq_out);
  endproperty
  a_hold: assert property (p_hold) else $error("unstable");
  property p_len; $fell(we_n) |-> !we_n [*8]; endproperty
  a_len: assert property (p_len) else $error("short");
  property p_idle; ready |-> ce_n && we_n && oe_n; endproperty
  a_idle: assert property (p_idle) else $error("idle");
endmodule
bind prot_host prot_host_props #(.AW(AW)) u_props (.core_clk, .sys_rst,
  .req, .op, .blk_addr, .password, .ready, .ack, .result, .fl_addr,
  .dq_out, .dq_oe_n, .dq_in, .ce_n, .we_n, .oe_n);

// File: prot_host_tb.sv
// Self-checking bench for the protection host
module prot_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, sys_rst, req;
  logic [3:0] op;
  logic [25:0] blk_addr;
  logic [63:0] password;
  wire ready, ack, dq_oe_n, ce_n, we_n, oe_n;
  wire [15:0] result, dq_out, dq_in;
  wire [25:0] fl_addr;
  int n_errors, checks_done;
  prot_host u_dut (.core_clk, .sys_rst, .req, .op, .blk_addr, .password,
    .ready, .ack, .result, .fl_addr, .dq_out, .dq_oe_n, .dq_in, .ce_n,
    .we_n, .oe_n);
  flash_prot_model u_dev (.core_clk, .sys_rst, .fl_addr, .dq_out, .ce_n,
    .we_n, .oe_n, .dq_in);
  task automatic conclude;
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [3:0] o, input logic [3:0] b);
    int i;
    @(negedge core_clk);
    op = o;
    blk_addr = {6'd0, b, 16'h0123};
    req = 1'b1;
    @(negedge core_clk);
    req = 1'b0;
    for (i = 0; i < 4000 && ack !== 1'b1; i++) @(negedge core_clk);
    if (i == 4000) begin
      n_errors++;
      conclude;
    end
  endtask
  task automatic rd(input logic [3:0] o, input logic [3:0] b,
    input logic [15:0] exp);
    run(o, b);
    check(result, exp);
  endtask
  task automatic hw_reset;
    @(negedge core_clk);
    sys_rst = 1'b1;
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
  endtask
  task automatic t_vol;
    rd(4'h2, 4'h1, 16'h1);
    run(4'h0, 4'h1);
    rd(4'h2, 4'h1, 16'h0);
    rd(4'h2, 4'h2, 16'h1);
    rd(4'hb, 4'h1, 16'h1);
    run(4'h1, 4'h1);
    rd(4'h2, 4'h1, 16'h1);
    rd(4'hb, 4'h1, 16'h0);
  endtask
  task automatic t_nv;
    run(4'h3, 4'h3);
    rd(4'h5, 4'h3, 16'h0);
    rd(4'h5, 4'h4, 16'h1);
    rd(4'hb, 4'h3, 16'h1);
    rd(4'h7, 4'h0, 16'h1);
    run(4'h4, 4'h0);
    rd(4'h5, 4'h3, 16'h1);
  endtask
  task automatic t_lock;
    run(4'h3, 4'h5);
    run(4'h6, 4'h0);
    rd(4'h7, 4'h0, 16'h0);
    run(4'h4, 4'h0);
    rd(4'h5, 4'h5, 16'h0);
    run(4'h3, 4'h6);
    rd(4'h5, 4'h6, 16'h1);
    hw_reset;
    rd(4'h7, 4'h0, 16'h1);
    rd(4'h5, 4'h5, 16'h0);
  endtask
  task automatic t_pw;
    password = 64'h4444_3333_2222_1111;
    run(4'h8, 4'h0);
    rd(4'h9, 4'h0, 16'h4444);
  endtask
  task automatic t_unlock;
    // Mode select flag has no command on this port list; set it directly
    u_dev.pmode = 1'b1;
    hw_reset;
    rd(4'h7, 4'h0, 16'h0);
    password = 64'h4444_3333_2222_1112;
    run(4'ha, 4'h0);
    rd(4'h7, 4'h0, 16'h0);
    run(4'h3, 4'h7);
    rd(4'h5, 4'h7, 16'h1);
    password = 64'h4444_3333_2222_1111;
    run(4'ha, 4'h0);
    rd(4'h7, 4'h0, 16'h1);
    rd(4'h9, 4'h0, 16'h0);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    n_errors = 0;
    checks_done = 0;
    req = 1'b0;
    op = 4'h0;
    blk_addr = 26'h0;
    password = 64'h0;
    sys_rst = 1'b1;
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    t_vol;
    t_nv;
    t_lock;
    t_pw;
    t_unlock;
    conclude;
  end
endmodule
